// >>> rtl/uiefc_map.svh
/*
 * Register offsets, field positions, reset values and fixed codes of the
 * interrupt identification and enhanced feature block.
 * Assumes inclusion by bare name from files under rtl/.
 */
`ifndef UIEFC_MAP_SVH
`define UIEFC_MAP_SVH

// ****************************************************************
// Register offsets on the 3-bit channel address
// ****************************************************************
`define UIEFC_OFS_IER      3'h1
`define UIEFC_OFS_IIR_FCR  3'h2
`define UIEFC_OFS_LCR      3'h3
`define UIEFC_OFS_MCR      3'h4
`define UIEFC_OFS_MSR_TCR  3'h6
`define UIEFC_OFS_SECOND_STOP_CHARACTER    3'h7
`define UIEFC_LCR_EXT_KEY  8'hBF

// ****************************************************************
// Field positions
// ****************************************************************
`define UIEFC_EFR_AUTO_CTS 7
`define UIEFC_EFR_AUTO_RTS 6
`define UIEFC_EFR_SPECIAL  5
`define UIEFC_EFR_WR_EN    4
`define UIEFC_IER_RXDATA   0
`define UIEFC_IER_THR      1
`define UIEFC_IER_LINE     2
`define UIEFC_IER_MODEM    3
`define UIEFC_IER_XOFF     5
`define UIEFC_IER_RTS      6
`define UIEFC_IER_CTS      7
`define UIEFC_FCR_FIFO_EN  0
`define UIEFC_MCR_RTS      1
`define UIEFC_MCR_TCR_SEL  6
`define UIEFC_MSR_CTS      4
`define UIEFC_IIR_FLOWLINE 5
`define UIEFC_IIR_XOFF     4

// ****************************************************************
// Protected write masks, reset values and codes
// ****************************************************************
`define UIEFC_IER_PROT     8'hF0
`define UIEFC_FCR_PROT     8'h30
`define UIEFC_MCR_PROT     8'hE0
`define UIEFC_RST_REG      8'h00
`define UIEFC_CODE_LINE    3'h3
`define UIEFC_CODE_TMO     3'h6
`define UIEFC_CODE_RXDATA  3'h2
`define UIEFC_CODE_THR     3'h1
`define UIEFC_CODE_NONE    3'h0
`define UIEFC_TCR_SHIFT    2

`endif

// >>> rtl/uiefc_pkg.sv
/*
 * Types of the interrupt identification and enhanced feature block.
 * Assumes uiefc_map.svh is available for the design files.
 */
package uiefc_pkg;

    // Pending sources, index 0 is highest priority
    typedef enum logic [2:0] {
        UIEFC_SRC_LINE   = 3'h0,
        UIEFC_SRC_TMO    = 3'h1,
        UIEFC_SRC_RXDATA = 3'h2,
        UIEFC_SRC_THR    = 3'h3,
        UIEFC_SRC_MODEM  = 3'h4,
        UIEFC_SRC_XOFF   = 3'h5,
        UIEFC_SRC_FLOW   = 3'h6
    } uiefc_src_t;

    // Auto-RTS hysteresis states
    typedef enum logic [1:0] {
        UIEFC_RTS_RUN  = 2'b01,
        UIEFC_RTS_HALT = 2'b10
    } uiefc_rts_t;

endpackage

// >>> rtl/uiefc_prio.sv
/*
 * Priority encoder: pending source vector to identification byte.
 * Assumes pending bits are already gated by their enables.
 */
`timescale 1ns/1ps
`default_nettype none
`include "uiefc_map.svh"

module uiefc_prio (
    input  wire logic [6:0] pend,
    input  wire logic       fifo_en,
    output logic [7:0]      interrupt_cause_id,
    output logic [2:0]      src,
    output logic            any
);
    always_comb begin
        interrupt_cause_id = {{2{fifo_en}}, 6'h01};
        src = uiefc_pkg::UIEFC_SRC_LINE;
        any = |pend;
        if (pend[0]) begin
            interrupt_cause_id[3:0] = {`UIEFC_CODE_LINE, 1'b0};
            src = uiefc_pkg::UIEFC_SRC_LINE;
        end else if (pend[1]) begin
            interrupt_cause_id[3:0] = {`UIEFC_CODE_TMO, 1'b0};
            src = uiefc_pkg::UIEFC_SRC_TMO;
        end else if (pend[2]) begin
            interrupt_cause_id[3:0] = {`UIEFC_CODE_RXDATA, 1'b0};
            src = uiefc_pkg::UIEFC_SRC_RXDATA;
        end else if (pend[3]) begin
            interrupt_cause_id[3:0] = {`UIEFC_CODE_THR, 1'b0};
            src = uiefc_pkg::UIEFC_SRC_THR;
        end else if (pend[4]) begin
            interrupt_cause_id[3:0] = {`UIEFC_CODE_NONE, 1'b0};
            src = uiefc_pkg::UIEFC_SRC_MODEM;
        end else if (pend[5]) begin
            interrupt_cause_id[3:0] = 4'h0;
            interrupt_cause_id[`UIEFC_IIR_XOFF] = 1'b1;
            src = uiefc_pkg::UIEFC_SRC_XOFF;
        end else if (pend[6]) begin
            interrupt_cause_id[4:0] = 5'h00;
            interrupt_cause_id[`UIEFC_IIR_FLOWLINE] = 1'b1;
            src = uiefc_pkg::UIEFC_SRC_FLOW;
        end
    end
endmodule

`default_nettype wire

// >>> rtl/uiefc_top.sv
/*
 * One UART channel's interrupt identification and enhanced feature logic,
 * with the channel registers it needs (INTERRUPT_ENABLE_REG, FIFO_CONTROL, LCR, MODEM_CONTROL_REG, MODEM_STATUS_REG, FLOW_THRESHOLD_CONTROL,
 * second stop character, enhanced feature control).
 * Assumes one-cycle read/write strobes from the channel's bus decoder on
 * clk, and FIFO status levels from the surrounding UART on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "uiefc_map.svh"

module uiefc_top #(
    parameter int FILL_W = 7
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic [2:0]        addr,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    input  wire logic [7:0]        wdata,
    input  wire logic              line_err,
    input  wire logic              rx_timeout,
    input  wire logic              rx_at_trigger,
    input  wire logic              tx_below_thr,
    input  wire logic              thr_write,
    input  wire logic              xoff_received,
    input  wire logic              rx_char_valid,
    input  wire logic [7:0]        rx_char,
    input  wire logic [FILL_W-1:0] rx_fill,
    input  wire logic              cts_n_pin,
    input  wire logic              dsr_n_pin,
    input  wire logic              ri_n_pin,
    input  wire logic              cd_n_pin,
    output logic [7:0]             rdata,
    output logic                   irq,
    output logic                   tx_halt,
    output logic                   rts_n,
    output logic [3:0]             swfc_mode,
    output logic                   fifo_enable
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0]             interrupt_enable_reg;
        logic [7:0]             fifo_control;
        logic [7:0]             lcr;
        logic [7:0]             modem_control_reg;
        logic [7:0]             flow_threshold_control;
        logic [7:0]             second_stop_character;
        logic [7:0]             enhanced_feature_control;
        logic [3:0]             s1;
        logic [3:0]             s2;
        logic [3:0]             s3;
        logic [3:0]             lines;
        logic [3:0]             delta;
        logic                   thr_pend;
        logic                   thr_prev;
        logic                   xoff_pend;
        logic                   flow_pend;
        uiefc_pkg::uiefc_rts_t  rts_st;
        logic [7:0]             rdata;
        logic                   irq;
        logic                   tx_halt;
        logic                   rts_n;
    } uiefc_state_t;

    uiefc_state_t st_q;
    uiefc_state_t st_d;

    logic [6:0] pend;
    logic [7:0] iir_val;
    logic [2:0] iir_src;
    logic       iir_any;

    function automatic logic [FILL_W-1:0] level(input logic [3:0] code);
        level = FILL_W'({code, 2'b00});
    endfunction

    // ****************************************************************
    // Pending sources and priority
    // ****************************************************************
    always_comb begin
        pend[0] = line_err & st_q.interrupt_enable_reg[`UIEFC_IER_LINE];
        pend[1] = rx_timeout & st_q.interrupt_enable_reg[`UIEFC_IER_RXDATA];
        pend[2] = rx_at_trigger & st_q.interrupt_enable_reg[`UIEFC_IER_RXDATA];
        pend[3] = st_q.thr_pend & st_q.interrupt_enable_reg[`UIEFC_IER_THR];
        pend[4] = (|st_q.delta) & st_q.interrupt_enable_reg[`UIEFC_IER_MODEM];
        pend[5] = st_q.xoff_pend & st_q.interrupt_enable_reg[`UIEFC_IER_XOFF];
        pend[6] = st_q.flow_pend &
                  (st_q.interrupt_enable_reg[`UIEFC_IER_CTS] | st_q.interrupt_enable_reg[`UIEFC_IER_RTS]);
    end

    uiefc_prio u_prio (
        .pend    (pend),
        .fifo_en (st_q.fifo_control[`UIEFC_FCR_FIFO_EN]),
        .interrupt_cause_id     (iir_val),
        .src     (iir_src),
        .any     (iir_any)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic ext;
        logic wen;
        logic tcr_sel;
        logic iir_rd;
        logic msr_rd;
        logic cts_rise;
        logic rts_rise;
        logic thr_cond;
        logic [7:0] modem_status_reg;
        ext      = (st_q.lcr == `UIEFC_LCR_EXT_KEY);
        wen      = st_q.enhanced_feature_control[`UIEFC_EFR_WR_EN];
        tcr_sel  = wen & st_q.modem_control_reg[`UIEFC_MCR_TCR_SEL];
        iir_rd   = rd_stb & (addr == `UIEFC_OFS_IIR_FCR) & ~ext;
        msr_rd   = rd_stb & (addr == `UIEFC_OFS_MSR_TCR) & ~tcr_sel;
        modem_status_reg      = {~st_q.lines, st_q.delta};
        st_d     = st_q;

        // Pin synchronisers, a change counts once stages two and three agree
        st_d.s1  = {cd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin};
        st_d.s2  = st_q.s1;
        st_d.s3  = st_q.s2;
        for (int i = 0; i < 4; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.lines[i] = st_q.s3[i];
            end
        end
        cts_rise = st_d.lines[0] & ~st_q.lines[0];

        // Register writes
        if (wr_stb) begin
            case (addr)
                `UIEFC_OFS_IER: begin
                    if (~st_q.lcr[7]) begin
                        st_d.interrupt_enable_reg = wen ? wdata :
                            (st_q.interrupt_enable_reg & `UIEFC_IER_PROT) |
                            (wdata & ~`UIEFC_IER_PROT);
                    end
                end
                `UIEFC_OFS_IIR_FCR: begin
                    if (ext) begin
                        st_d.enhanced_feature_control = wdata;
                    end else begin
                        st_d.fifo_control = wen ? wdata :
                            (st_q.fifo_control & `UIEFC_FCR_PROT) |
                            (wdata & ~`UIEFC_FCR_PROT);
                    end
                end
                `UIEFC_OFS_LCR: begin
                    st_d.lcr = wdata;
                end
                `UIEFC_OFS_MCR: begin
                    if (~ext) begin
                        st_d.modem_control_reg = wen ? wdata :
                            (st_q.modem_control_reg & `UIEFC_MCR_PROT) |
                            (wdata & ~`UIEFC_MCR_PROT);
                    end
                end
                `UIEFC_OFS_MSR_TCR: begin
                    if (tcr_sel & ~ext) begin
                        st_d.flow_threshold_control = wdata;
                    end
                end
                `UIEFC_OFS_SECOND_STOP_CHARACTER: begin
                    if (ext) begin
                        st_d.second_stop_character = wdata;
                    end
                end
                default: begin
                end
            endcase
        end

        // Register reads
        if (rd_stb) begin
            case (addr)
                `UIEFC_OFS_IER:      st_d.rdata = st_q.lcr[7] ? 8'h00 : st_q.interrupt_enable_reg;
                `UIEFC_OFS_IIR_FCR:  st_d.rdata = ext ? st_q.enhanced_feature_control : iir_val;
                `UIEFC_OFS_LCR:      st_d.rdata = st_q.lcr;
                `UIEFC_OFS_MCR:      st_d.rdata = st_q.modem_control_reg;
                `UIEFC_OFS_MSR_TCR:  st_d.rdata = tcr_sel ? st_q.flow_threshold_control : modem_status_reg;
                `UIEFC_OFS_SECOND_STOP_CHARACTER:    st_d.rdata = ext ? st_q.second_stop_character : 8'h00;
                default:             st_d.rdata = 8'h00;
            endcase
        end

        // Modem change flags, set wins over the clearing read
        if (msr_rd) begin
            st_d.delta = 4'h0;
        end
        st_d.delta = st_d.delta | (st_d.lines ^ st_q.lines);

        // Transmit space: new edge of enable or level raises it
        thr_cond    = tx_below_thr & st_q.interrupt_enable_reg[`UIEFC_IER_THR];
        st_d.thr_prev = thr_cond;
        if ((iir_rd && iir_src == uiefc_pkg::UIEFC_SRC_THR && iir_any)
            || thr_write) begin
            st_d.thr_pend = 1'b0;
        end
        if (thr_cond & ~st_q.thr_prev) begin
            st_d.thr_pend = 1'b1;
        end

        // Stop or special character flag
        if (iir_rd && iir_src == uiefc_pkg::UIEFC_SRC_XOFF && iir_any) begin
            st_d.xoff_pend = 1'b0;
        end
        if (xoff_received || (rx_char_valid &&
            st_q.enhanced_feature_control[`UIEFC_EFR_SPECIAL] && rx_char == st_q.second_stop_character)) begin
            st_d.xoff_pend = 1'b1;
        end

        // Automatic RTS hysteresis
        case (st_q.rts_st)
            uiefc_pkg::UIEFC_RTS_RUN: begin
                if (rx_fill >= level(st_q.flow_threshold_control[3:0])) begin
                    st_d.rts_st = uiefc_pkg::UIEFC_RTS_HALT;
                end
            end
            uiefc_pkg::UIEFC_RTS_HALT: begin
                if (rx_fill <= level(st_q.flow_threshold_control[7:4])) begin
                    st_d.rts_st = uiefc_pkg::UIEFC_RTS_RUN;
                end
            end
            default: begin
                st_d.rts_st = uiefc_pkg::UIEFC_RTS_RUN;
            end
        endcase
        if (st_q.enhanced_feature_control[`UIEFC_EFR_AUTO_RTS]) begin
            st_d.rts_n = (st_d.rts_st == uiefc_pkg::UIEFC_RTS_HALT);
        end else begin
            st_d.rts_n = ~st_d.modem_control_reg[`UIEFC_MCR_RTS];
        end
        rts_rise = st_d.rts_n & ~st_q.rts_n;

        // Flow line going inactive
        if (iir_rd && iir_src == uiefc_pkg::UIEFC_SRC_FLOW && iir_any) begin
            st_d.flow_pend = 1'b0;
        end
        if ((cts_rise & st_q.interrupt_enable_reg[`UIEFC_IER_CTS]) |
            (rts_rise & st_q.interrupt_enable_reg[`UIEFC_IER_RTS])) begin
            st_d.flow_pend = 1'b1;
        end

        st_d.tx_halt = st_d.enhanced_feature_control[`UIEFC_EFR_AUTO_CTS] & st_d.lines[0];
        st_d.irq     = |pend;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q        <= '0;
            st_q.enhanced_feature_control    <= `UIEFC_RST_REG;
            st_q.s1     <= 4'hF;
            st_q.s2     <= 4'hF;
            st_q.s3     <= 4'hF;
            st_q.lines  <= 4'hF;
            st_q.rts_st <= uiefc_pkg::UIEFC_RTS_RUN;
            st_q.rts_n  <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata       = st_q.rdata;
    assign irq         = st_q.irq;
    assign tx_halt     = st_q.tx_halt;
    assign rts_n       = st_q.rts_n;
    assign swfc_mode   = st_q.enhanced_feature_control[3:0];
    assign fifo_enable = st_q.fifo_control[`UIEFC_FCR_FIFO_EN];
endmodule

`default_nettype wire

// >>> tb/uiefc_chk.sv
/* Concurrent checks on the uiefc_top ports, with shadow registers.
   Assumes every register write arrives through wr_stb. */
`timescale 1ns/1ps
`default_nettype none

module uiefc_chk (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic [2:0] addr,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    input wire logic [7:0] wdata,
    input wire logic       cts_n_pin,
    input wire logic [7:0] rdata,
    input wire logic       irq,
    input wire logic       tx_halt,
    input wire logic       rts_n,
    input wire logic [3:0] swfc_mode,
    input wire logic       fifo_enable
);
    // ************************************
    // Shadows and properties
    // ************************************
    logic [7:0] lcr_q;
    logic [7:0] efr_q;
    logic [7:0] ier_q;
    logic       ext;
    logic       rd_iir;
    assign ext = (lcr_q == 8'hBF);
    assign rd_iir = rd_stb && (addr == 3'h2) && !ext;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lcr_q <= 8'h00;
            efr_q <= 8'h00;
            ier_q <= 8'h00;
        end else if (wr_stb) begin
            if (addr == 3'h3) lcr_q <= wdata;
            if (addr == 3'h2 && ext) efr_q <= wdata;
            if (addr == 3'h1 && !lcr_q[7])
                ier_q <= efr_q[4] ? wdata : {ier_q[7:4], wdata[3:0]};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    rst_vals_a: assert property ($rose(nrst) |->
        rdata == 8'h00 && !irq && !tx_halt && rts_n && swfc_mode == 4'h0)
        else $error("outputs wrong after reset");
    iir_mirror_a: assert property (
        rd_iir |=> rdata[7:6] == {2{fifo_enable}})
        else $error("ident top bits differ from fifo enable");
    iir_bit0_a: assert property (rd_iir && irq |=> !rdata[0])
        else $error("ident bit 0 high while interrupt pends");
    iir_code_a: assert property (rd_iir |=>
        rdata[5:0] inside {6'h01, 6'h06, 6'h0C, 6'h04, 6'h02, 6'h00,
                           6'h10, 6'h20})
        else $error("illegal ident code");
    cts_off_a: assert property (
        !efr_q[7] && !$past(efr_q[7]) |-> !tx_halt)
        else $error("transmit halted without auto flow");
    cts_halt_a: assert property (
        (efr_q[7] && cts_n_pin) [*8] |-> tx_halt)
        else $error("transmit not halted by inactive line");
    mode_follow_a: assert property (
        wr_stb && addr == 3'h2 && ext |=> ##1
        swfc_mode == $past(wdata[3:0], 2))
        else $error("flow mode not taken from feature write");
    ier_mask_a: assert property (
        ier_q == 8'h00 && $past(ier_q) == 8'h00 |-> !irq)
        else $error("interrupt with all sources disabled");
    cover property (rd_iir && irq);
    cover property ($rose(tx_halt));
    cover property ($fell(rts_n));
endmodule

bind uiefc_top uiefc_chk u_chk (.clk(clk), .nrst(nrst), .addr(addr),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .wdata(wdata),
    .cts_n_pin(cts_n_pin), .rdata(rdata), .irq(irq), .tx_halt(tx_halt),
    .rts_n(rts_n), .swfc_mode(swfc_mode), .fifo_enable(fifo_enable));
`default_nettype wire

// >>> tb/uiefc_host.sv
/* Host processor model: strobed register reads and writes.
   Assumes rdata is valid one cycle after the read strobe. */
`timescale 1ns/1ps
`default_nettype none

module uiefc_host (
    input  wire logic       clk,
    output logic [2:0]      addr,
    output logic            wr_stb,
    output logic            rd_stb,
    output logic [7:0]      wdata,
    input  wire logic [7:0] rdata
);
    // ************************************
    // Bus cycles
    // ************************************
    initial begin
        addr = 3'h0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        wdata = 8'h00;
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        wdata <= ~d;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
/* Self-checking bench for uiefc_top through the host model.
   Assumes the checker is bound to the design by its own file. */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    // ************************************
    // Stimulus and checks
    // ************************************
    logic       clk, nrst, wr_stb, rd_stb, line_err, rx_timeout;
    logic       rx_at_trigger, tx_below_thr, thr_write, xoff_received;
    logic       rx_char_valid, cts_n_pin, dsr_n_pin, ri_n_pin, cd_n_pin;
    logic       irq, tx_halt, rts_n, fifo_enable;
    logic [2:0] addr;
    logic [7:0] wdata, rx_char, rdata, outs;
    logic [6:0] rx_fill;
    logic [3:0] swfc_mode;
    logic [6:0] fills [4] = '{7'h07, 7'h08, 7'h05, 7'h04};
    logic [7:0] fexp [4] = '{8'h15, 8'h95, 8'h95, 8'h15};
    int         errors, n_checks;
    assign outs = {rts_n, tx_halt, irq, fifo_enable, swfc_mode};
    uiefc_host u_host (.clk(clk), .addr(addr), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .wdata(wdata), .rdata(rdata));
    uiefc_top #(.FILL_W(7)) u_dut (.clk(clk), .nrst(nrst), .addr(addr),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .wdata(wdata),
        .line_err(line_err), .rx_timeout(rx_timeout),
        .rx_at_trigger(rx_at_trigger), .tx_below_thr(tx_below_thr),
        .thr_write(thr_write), .xoff_received(xoff_received),
        .rx_char_valid(rx_char_valid), .rx_char(rx_char),
        .rx_fill(rx_fill), .cts_n_pin(cts_n_pin), .dsr_n_pin(dsr_n_pin),
        .ri_n_pin(ri_n_pin), .cd_n_pin(cd_n_pin), .rdata(rdata),
        .irq(irq), .tx_halt(tx_halt), .rts_n(rts_n),
        .swfc_mode(swfc_mode), .fifo_enable(fifo_enable));
    always #50 clk = ~clk;
    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.rd(a, d);
        chk("rdata", d, exp);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    initial begin
        {clk, nrst, line_err, rx_timeout, rx_at_trigger} = 5'h00;
        {tx_below_thr, thr_write, xoff_received, rx_char_valid} = 4'h0;
        {cts_n_pin, dsr_n_pin, ri_n_pin, cd_n_pin} = 4'hF;
        rx_char = 8'h00;
        rx_fill = 7'h00;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        wt(1);
        chk("outs", outs, 8'h80);
        rdc(3'h0, 8'h00);
        u_host.wr(3'h3, 8'hBF);
        rdc(3'h2, 8'h00);
        // Auto-RTS stays off until thresholds are programmed
        u_host.wr(3'h2, 8'hB5);
        rdc(3'h2, 8'hB5);
        u_host.wr(3'h7, 8'h5A);
        u_host.wr(3'h3, 8'h00);
        u_host.wr(3'h2, 8'h01);
        wt(8);
        chk("outs", outs, 8'hD5);
        @(posedge clk) cts_n_pin <= 1'b0;
        u_host.wr(3'h4, 8'h40);
        u_host.wr(3'h6, 8'h12);
        u_host.wr(3'h4, 8'h00);
        u_host.wr(3'h3, 8'hBF);
        u_host.wr(3'h2, 8'hF5);
        u_host.wr(3'h3, 8'h00);
        wt(8);
        chk("outs", outs, 8'h15);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) rx_fill <= fills[i];
            wt(4);
            chk("outs", outs, fexp[i]);
        end
        rdc(3'h6, 8'h11);
        rdc(3'h6, 8'h10);
        u_host.wr(3'h1, 8'hFF);
        rdc(3'h2, 8'hC1);
        @(posedge clk) cts_n_pin <= 1'b1;
        wt(8);
        rdc(3'h2, 8'hC0);
        rdc(3'h6, 8'h01);
        rdc(3'h2, 8'hE0);
        rdc(3'h2, 8'hC1);
        @(posedge clk) xoff_received <= 1'b1;
        @(posedge clk) xoff_received <= 1'b0;
        rdc(3'h2, 8'hD0);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) rx_char <= i ? 8'h5A : 8'h11;
            rx_char_valid <= 1'b1;
            @(posedge clk) rx_char_valid <= 1'b0;
            rdc(3'h2, i ? 8'hD0 : 8'hC1);
        end
        @(posedge clk) {line_err, rx_timeout, rx_at_trigger} <= 3'h7;
        tx_below_thr <= 1'b1;
        dsr_n_pin <= 1'b0;
        wt(8);
        rdc(3'h2, 8'hC6);
        @(posedge clk) line_err <= 1'b0;
        rdc(3'h2, 8'hCC);
        @(posedge clk) rx_timeout <= 1'b0;
        rdc(3'h2, 8'hC4);
        @(posedge clk) rx_at_trigger <= 1'b0;
        rdc(3'h2, 8'hC2);
        rdc(3'h2, 8'hC0);
        chk("outs", outs, 8'h75);
        rdc(3'h6, 8'h22);
        rdc(3'h2, 8'hC1);
        wt(2);
        chk("outs", outs, 8'h55);
        u_host.wr(3'h1, 8'h00);
        @(posedge clk) line_err <= 1'b1;
        wt(4);
        rdc(3'h2, 8'hC1);
        chk("outs", outs, 8'h55);
        @(posedge clk) line_err <= 1'b0;
        u_host.wr(3'h1, 8'h02);
        wt(2);
        rdc(3'h2, 8'hC2);
        u_host.wr(3'h3, 8'hBF);
        u_host.wr(3'h2, 8'h05);
        u_host.wr(3'h3, 8'h00);
        u_host.wr(3'h1, 8'hFF);
        rdc(3'h1, 8'h0F);
        wt(4);
        chk("outs", outs, 8'h95);
        tally_and_finish();
    end
endmodule
`default_nettype wire
